// [hw/rpb_receiver_backend.sv]
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "rpb_regs.svh"
// How it works
// [R1] xaui only: 16-word lane buffers, state machine hunts k28.3 on all four lanes
// [R2] four aligned /A/ columns raise the lanes-aligned flag
// [R3] four consecutive misaligned /A/ drop the flag and restart the hunt
// [R4] skip inserted when buffer runs low, deleted when it runs high
// [R5] thresholds leave margin for 100 ppm xaui/gige and 300 ppm pipe/basic
// [R6] serial rapidio bypasses the rate matcher; user logic compensates
// [R7] xaui adds or drops whole /R/ columns by buffer fill
// [R8] pipe finds k28.5 plus k28.0 skip sets, adds or drops k28.0
// [R9] pipe overflow drops incoming data until not full, no pointer reset
// [R10] pipe underflow outputs 9'h1fe until buffer holds data again
// [R11] pipe overflow and underflow reported on pipe status
// [R12] gige adds or drops only k28.5 d16.2 pairs unless enhanced, twenty bits at once
// [R13] enhanced gige may also drop configuration sets
// [R14] basic drops programmed skips freely, inserts only while run below five
// [R15] decoder yields 8 data bits plus control flag in every mode
// [R16] invalid code group raises code error
// [R17] disparity error raises both flags, same latency as the symbol
// [R18] gige replaces invalid groups by k30.7; xaui maps to xgmii codes
// [R19] bytes paired into two-byte words except in gige
// [R20] byte order may swap; user logic must reorder
// [R21] output buffer eight words deep in pipe, four otherwise
// [R22] loopback enable routes serializer to recovery in gige and srio only
module rpb_receiver_backend (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire rpb_pkg::rpb_col_t in_col,
  input wire logic user_ready,
  output logic lanes_aligned,
  output logic [2:0] pipe_status,
  output logic rx_valid,
  output rpb_pkg::rpb_word_t rx_word,
  output logic serial_lpbk
);

  function automatic logic [5:0] dec6(input logic [5:0] s);
    case (s)
      6'b100111, 6'b011000: return {1'b1, 5'd0};
      6'b011101, 6'b100010: return {1'b1, 5'd1};
      6'b101101, 6'b010010: return {1'b1, 5'd2};
      6'b110001: return {1'b1, 5'd3};
      6'b110101, 6'b001010: return {1'b1, 5'd4};
      6'b101001: return {1'b1, 5'd5};
      6'b011001: return {1'b1, 5'd6};
      6'b111000, 6'b000111: return {1'b1, 5'd7};
      6'b111001, 6'b000110: return {1'b1, 5'd8};
      6'b100101: return {1'b1, 5'd9};
      6'b010101: return {1'b1, 5'd10};
      6'b110100: return {1'b1, 5'd11};
      6'b001101: return {1'b1, 5'd12};
      6'b101100: return {1'b1, 5'd13};
      6'b011100: return {1'b1, 5'd14};
      6'b010111, 6'b101000: return {1'b1, 5'd15};
      6'b011011, 6'b100100: return {1'b1, 5'd16};
      6'b100011: return {1'b1, 5'd17};
      6'b010011: return {1'b1, 5'd18};
      6'b110010: return {1'b1, 5'd19};
      6'b001011: return {1'b1, 5'd20};
      6'b101010: return {1'b1, 5'd21};
      6'b011010: return {1'b1, 5'd22};
      6'b111010, 6'b000101: return {1'b1, 5'd23};
      6'b110011, 6'b001100: return {1'b1, 5'd24};
      6'b100110: return {1'b1, 5'd25};
      6'b010110: return {1'b1, 5'd26};
      6'b110110, 6'b001001: return {1'b1, 5'd27};
      6'b001110, 6'b001111, 6'b110000: return {1'b1, 5'd28};
      6'b101110, 6'b010001: return {1'b1, 5'd29};
      6'b011110, 6'b100001: return {1'b1, 5'd30};
      6'b101011, 6'b010100: return {1'b1, 5'd31};
      default: return 6'h00;
    endcase
  endfunction : dec6

  function automatic logic [3:0] dec4(input logic [3:0] f);
    case (f)
      4'b1011, 4'b0100: return 4'h8;
      4'b1001: return 4'h9;
      4'b0101: return 4'ha;
      4'b1100, 4'b0011: return 4'hb;
      4'b1101, 4'b0010: return 4'hc;
      4'b1010: return 4'hd;
      4'b0110: return 4'he;
      4'b1110, 4'b0001, 4'b0111, 4'b1000: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction : dec4

  // returns {bad, k, byte}; symbol bits are abcdei fghj from msb down
  function automatic logic [9:0] dec10(input logic [9:0] c);
    logic [5:0] a;
    logic [3:0] b;
    logic kx;
    a = dec6(c[9:4]);
    // rd+ k28 flips fghj so one table serves both forms
    b = dec4((c[9:4] == 6'b110000) ? ~c[3:0] : c[3:0]);
    kx = (c[3:0] == 4'b1000 || c[3:0] == 4'b0111) &&
         (c[9:4] == 6'b111010 || c[9:4] == 6'b000101 || c[9:4] == 6'b110110 ||
          c[9:4] == 6'b001001 || c[9:4] == 6'b101110 || c[9:4] == 6'b010001 ||
          c[9:4] == 6'b011110 || c[9:4] == 6'b100001);
    return {~a[5] | ~b[3], (c[9:4] == 6'b001111) | (c[9:4] == 6'b110000) | kx, b[2:0], a[4:0]};
  endfunction : dec10

  // {disparity error, code error, new rd}; rd high means positive
  function automatic logic [2:0] rd_chk(input logic [9:0] c, input logic rd);
    logic [2:0] n6;
    logic [2:0] n4;
    logic r;
    logic de;
    logic ce;
    n6 = 3'($countones(c[9:4]));
    n4 = 3'($countones(c[3:0]));
    r = rd;
    de = 1'b0;
    ce = 1'b0;
    if (n6 == 3'h4) begin
      de = r;
      r = 1'b1;
    end else if (n6 == 3'h2) begin
      de = ~r;
      r = 1'b0;
    end else if (n6 != 3'h3) begin
      ce = 1'b1;
    end
    if (n4 == 3'h3) begin
      de = de | r;
      r = 1'b1;
    end else if (n4 == 3'h1) begin
      de = de | ~r;
      r = 1'b0;
    end else if (n4 != 3'h2) begin
      ce = 1'b1;
    end
    return {de, ce, r};
  endfunction : rd_chk

  function automatic logic sym_is(input logic [9:0] c, input logic [8:0] v);
    logic [9:0] d;
    d = dec10(c);
    return !d[9] && d[8:0] == v;
  endfunction : sym_is

  function automatic logic is_skip(input rpb_pkg::rpb_col_t c, input rpb_pkg::rpb_mode_t m,
                                   input logic [9:0] pat);
    case (m)
      rpb_pkg::mode_xaui: return sym_is(c[0], `RPB_K28_0) && sym_is(c[1], `RPB_K28_0) &&
                                 sym_is(c[2], `RPB_K28_0) && sym_is(c[3], `RPB_K28_0); // see [R7]
      rpb_pkg::mode_pipe: return sym_is(c[0], `RPB_K28_0); // see [R8]
      rpb_pkg::mode_basic: return c[0] == pat;
      default: return 1'b0;
    endcase
  endfunction : is_skip

  logic [31:0] ctrl;
  logic [9:0] skip_pat;
  logic pcf_ovf_st;
  logic rm_ovf_st;
  logic rm_udf_st;
  rpb_pkg::rpb_mode_t mode;
  logic enh;
  logic stat_w1c;
  assign mode = rpb_pkg::rpb_mode_t'(ctrl[`RPB_CTRL_MODE_MSB:0]);
  assign enh = ctrl[`RPB_CTRL_ENH_BIT];
  assign stat_w1c = reg_wr && reg_addr == `RPB_ADDR_STAT;

  // lane aligner
  logic [9:0] al_buf [4][16];
  logic [3:0] al_wp;
  logic [3:0] al_rp [4];
  logic [3:0] al_aidx [4];
  logic [3:0] next_aidx [4];
  logic [3:0] al_seen;
  logic [3:0] next_seen;
  logic [3:0] al_amask;
  rpb_pkg::rpb_col_t al_rd;
  rpb_pkg::rpb_col_t al_col;
  logic al_vld;
  rpb_pkg::rpb_al_state_t al_state;
  logic [2:0] al_cnt;
  logic [2:0] al_miss;

  always_comb begin
    for (int l = 0; l < 4; l++) begin
      al_rd[l] = al_buf[l][al_rp[l]];
      al_amask[l] = sym_is(al_rd[l], `RPB_K28_3);
      next_seen[l] = al_seen[l];
      next_aidx[l] = al_aidx[l];
      if (sym_is(in_col[l], `RPB_K28_3)) begin // see [R1]
        next_seen[l] = 1'b1;
        next_aidx[l] = al_wp;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en && in_valid && mode == rpb_pkg::mode_xaui) begin
      for (int l = 0; l < 4; l++) al_buf[l][al_wp] <= in_col[l];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      al_state <= rpb_pkg::al_hunt;
      al_wp <= 4'h0;
      al_seen <= 4'h0;
      al_cnt <= 3'h0;
      al_miss <= 3'h0;
      al_vld <= 1'b0;
      al_col <= '0;
      for (int l = 0; l < 4; l++) begin
        al_rp[l] <= 4'h0;
        al_aidx[l] <= 4'h0;
      end
    end else if (clk_en) begin
      al_vld <= 1'b0;
      if (mode != rpb_pkg::mode_xaui) begin // see [R1]
        al_col <= in_col;
        al_vld <= in_valid;
        al_state <= rpb_pkg::al_hunt;
        al_seen <= 4'h0;
        al_cnt <= 3'h0;
        al_miss <= 3'h0;
      end else if (in_valid) begin
        al_wp <= al_wp + 4'h1;
        case (al_state)
          rpb_pkg::al_hunt: begin
            al_seen <= next_seen;
            al_aidx <= next_aidx;
            if (&next_seen) begin
              al_state <= rpb_pkg::al_acq;
              al_seen <= 4'h0;
              al_rp <= next_aidx;
            end
          end
          rpb_pkg::al_acq, rpb_pkg::al_locked: begin
            al_col <= al_rd;
            al_vld <= 1'b1;
            for (int l = 0; l < 4; l++) al_rp[l] <= al_rp[l] + 4'h1;
            if (&al_amask) begin
              al_miss <= 3'h0;
              if (al_cnt == `RPB_AL_COLS - 3'h1) al_state <= rpb_pkg::al_locked; // see [R2]
              else al_cnt <= al_cnt + 3'h1;
            end else if (|al_amask) begin
              if (al_miss == `RPB_AL_MISS - 3'h1) begin // see [R3]
                al_state <= rpb_pkg::al_hunt;
                al_cnt <= 3'h0;
                al_miss <= 3'h0;
              end else begin
                al_miss <= al_miss + 3'h1;
              end
            end
          end
          default: al_state <= rpb_pkg::al_hunt;
        endcase
      end
    end
  end

  // rate matcher; read side runs every enabled cycle, write side at source rate
  rpb_pkg::rpb_col_t rm_buf [16];
  logic [4:0] rm_wp;
  logic [4:0] rm_rp;
  logic [4:0] rm_cnt;
  logic rm_primed;
  logic rm_ins;
  logic rm_prev_k;
  logic rm_prev_sos;
  logic [2:0] rm_skip_run;
  rpb_pkg::rpb_col_t rm_head;
  rpb_pkg::rpb_col_t rm_next;
  rpb_pkg::rpb_col_t rm_out;
  rpb_pkg::rpb_col_t rm_col;
  logic rm_vld;
  logic rm_uf;
  logic rm_del;
  logic rm_rewind;
  logic rm_wr;
  logic rm_emit;
  logic rm_pop;
  logic rm_ins_start;
  logic rm_ovf_ev;
  logic rm_udf_ev;
  logic g_pair;
  assign rm_cnt = rm_wp - rm_rp;

  always_comb begin
    rm_head = rm_buf[rm_rp[3:0]];
    rm_next = rm_buf[rm_rp[3:0] + 4'h1];
    rm_out = rm_ins ? rm_next : rm_head;
    g_pair = sym_is(al_col[0], `RPB_D16_2) ||
             (enh && (sym_is(al_col[0], `RPB_D21_5) || sym_is(al_col[0], `RPB_D2_2))); // see [R13]
    rm_del = 1'b0;
    rm_rewind = 1'b0;
    // high mark leaves four words of slack for the ppm drift across a packet, see [R5]
    if (al_vld && rm_cnt >= `RPB_RM_HI) begin // see [R4]
      case (mode)
        rpb_pkg::mode_xaui, rpb_pkg::mode_basic: rm_del = is_skip(al_col, mode, skip_pat); // see [R14]
        rpb_pkg::mode_pipe: rm_del = is_skip(al_col, mode, skip_pat) && rm_prev_sos; // see [R8]
        rpb_pkg::mode_gige: rm_rewind = rm_prev_k && g_pair; // see [R12]
        default: rm_del = 1'b0;
      endcase
    end
    rm_ovf_ev = al_vld && rm_cnt == `RPB_RM_DEPTH;
    rm_wr = al_vld && !rm_del && !rm_rewind && !rm_ovf_ev && mode != rpb_pkg::mode_srio; // see [R9]
    rm_ins_start = 1'b0;
    if (rm_cnt < `RPB_RM_LO && rm_cnt != 5'h0) begin // see [R4]
      case (mode)
        rpb_pkg::mode_xaui, rpb_pkg::mode_pipe: rm_ins_start = is_skip(rm_head, mode, skip_pat);
        rpb_pkg::mode_basic: rm_ins_start = is_skip(rm_head, mode, skip_pat) &&
                                            rm_skip_run < `RPB_BASIC_MAX_SKIP; // see [R14]
        rpb_pkg::mode_gige: rm_ins_start = rm_cnt >= 5'h2 && sym_is(rm_head[0], `RPB_K28_5) &&
                                           sym_is(rm_next[0], `RPB_D16_2); // see [R12]
        default: rm_ins_start = 1'b0;
      endcase
    end
    rm_emit = rm_primed && rm_cnt != 5'h0;
    rm_pop = rm_emit && !rm_ins_start && !rm_ins;
    rm_udf_ev = rm_primed && rm_cnt == 5'h0 && mode == rpb_pkg::mode_pipe;
  end

  always_ff @(posedge clock) begin
    if (clk_en && rm_wr) rm_buf[rm_wp[3:0]] <= al_col;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rm_wp <= 5'h0;
      rm_prev_k <= 1'b0;
      rm_prev_sos <= 1'b0;
    end else if (clk_en) begin
      if (al_vld) begin
        rm_prev_k <= sym_is(al_col[0], `RPB_K28_5);
        rm_prev_sos <= sym_is(al_col[0], `RPB_K28_5) || sym_is(al_col[0], `RPB_K28_0);
      end
      // the k28.5 of a dropped pair is still unread, so stepping back removes it
      if (rm_rewind) rm_wp <= rm_wp - 5'h1; // see [R12]
      else if (rm_wr) rm_wp <= rm_wp + 5'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rm_rp <= 5'h0;
      rm_primed <= 1'b0;
      rm_ins <= 1'b0;
      rm_skip_run <= 3'h0;
      rm_vld <= 1'b0;
      rm_uf <= 1'b0;
      rm_col <= '0;
    end else if (clk_en) begin
      rm_vld <= 1'b0;
      rm_uf <= 1'b0;
      if (mode == rpb_pkg::mode_srio) begin // see [R6]
        rm_col <= al_col;
        rm_vld <= al_vld;
      end else begin
        if (rm_cnt >= `RPB_RM_MID) rm_primed <= 1'b1;
        else if (rm_cnt == 5'h0 && mode != rpb_pkg::mode_pipe) rm_primed <= 1'b0;
        if (rm_emit) begin
          rm_vld <= 1'b1;
          rm_col <= rm_out;
        end else if (rm_udf_ev) begin // see [R10]
          rm_vld <= 1'b1;
          rm_uf <= 1'b1;
        end
        if (rm_pop) rm_rp <= rm_rp + 5'h1;
        rm_ins <= rm_emit && mode == rpb_pkg::mode_gige && rm_ins_start && !rm_ins;
        if (rm_emit) begin
          if (!is_skip(rm_out, mode, skip_pat)) rm_skip_run <= 3'h0;
          else if (rm_skip_run != `RPB_BASIC_MAX_SKIP) rm_skip_run <= rm_skip_run + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pipe_status <= `RPB_PST_OK;
    end else if (clk_en) begin
      if (mode != rpb_pkg::mode_pipe) pipe_status <= `RPB_PST_OK;
      else if (rm_ovf_ev) pipe_status <= `RPB_PST_OVF; // see [R11]
      else if (rm_udf_ev) pipe_status <= `RPB_PST_UDF; // see [R11]
      else pipe_status <= `RPB_PST_OK;
    end
  end

  // decoder and receiver state machine, one stage
  rpb_pkg::rpb_sym_t [3:0] next_sym;
  rpb_pkg::rpb_sym_t [3:0] dec_sym;
  logic [3:0] next_rd;
  logic [3:0] dec_rd;
  logic dec_vld;

  always_comb begin
    logic [9:0] d;
    logic [2:0] chk;
    d = 10'h000;
    chk = 3'h0;
    for (int l = 0; l < 4; l++) begin
      d = dec10(rm_col[l]); // see [R15]
      chk = rd_chk(rm_col[l], dec_rd[l]);
      next_sym[l].err = d[9] | chk[1] | chk[2]; // see [R16]
      next_sym[l].derr = chk[2]; // see [R17]
      next_sym[l].k = d[8];
      next_sym[l].data = d[7:0];
      next_rd[l] = chk[0];
      if (rm_uf) begin // see [R10]
        next_sym[l] = {2'b00, `RPB_K30_7};
        next_rd[l] = dec_rd[l];
      end else if (mode == rpb_pkg::mode_gige && next_sym[l].err) begin
        {next_sym[l].k, next_sym[l].data} = `RPB_K30_7; // see [R18]
      end else if (mode == rpb_pkg::mode_xaui) begin
        if (next_sym[l].err) begin
          {next_sym[l].k, next_sym[l].data} = `RPB_K30_7; // see [R18]
        end else if (d[8:0] == `RPB_K28_5 || d[8:0] == `RPB_K28_3 || d[8:0] == `RPB_K28_0) begin
          next_sym[l].data = `RPB_XGMII_IDLE; // see [R18]
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dec_sym <= '0;
      dec_rd <= 4'h0;
      dec_vld <= 1'b0;
    end else if (clk_en) begin
      dec_vld <= rm_vld;
      if (rm_vld) begin
        dec_sym <= next_sym; // see [R17]
        dec_rd <= next_rd;
      end
    end
  end

  // byte deserializer; pairing phase is arbitrary after reset
  rpb_pkg::rpb_sym_t [3:0] bd_lo;
  logic bd_ph;
  rpb_pkg::rpb_word_t bd_word;
  logic bd_vld;

  always_ff @(posedge clock) begin
    if (srst) begin
      bd_lo <= '0;
      bd_ph <= 1'b0;
      bd_word <= '0;
      bd_vld <= 1'b0;
    end else if (clk_en) begin
      bd_vld <= 1'b0;
      if (dec_vld) begin
        if (mode == rpb_pkg::mode_gige) begin // see [R19]
          bd_word <= '0;
          for (int l = 0; l < 4; l++) bd_word[2 * l] <= dec_sym[l];
          bd_vld <= 1'b1;
          bd_ph <= 1'b0;
        end else if (!bd_ph) begin
          bd_lo <= dec_sym;
          bd_ph <= 1'b1;
        end else begin
          for (int l = 0; l < 4; l++) begin
            bd_word[2 * l] <= bd_lo[l]; // see [R19]
            bd_word[2 * l + 1] <= dec_sym[l];
          end
          bd_vld <= 1'b1;
          bd_ph <= 1'b0;
        end
      end
    end
  end

  // output buffer toward user logic
  rpb_pkg::rpb_word_t pcf_mem [8];
  logic [3:0] pcf_wp;
  logic [3:0] pcf_rp;
  logic [3:0] pcf_cnt;
  logic [3:0] pcf_depth;
  logic pcf_ovf_ev;
  logic pcf_wr;
  logic pcf_rd;
  assign pcf_cnt = pcf_wp - pcf_rp;
  assign pcf_depth = (mode == rpb_pkg::mode_pipe) ? `RPB_PCF_DEPTH_PIPE : `RPB_PCF_DEPTH; // see [R21]
  assign pcf_ovf_ev = bd_vld && pcf_cnt >= pcf_depth;
  assign pcf_wr = bd_vld && !pcf_ovf_ev;
  assign pcf_rd = pcf_cnt != 4'h0 && (!rx_valid || user_ready);

  always_ff @(posedge clock) begin
    if (clk_en && pcf_wr) pcf_mem[pcf_wp[2:0]] <= bd_word;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pcf_wp <= 4'h0;
      pcf_rp <= 4'h0;
      rx_valid <= 1'b0;
      rx_word <= '0;
    end else if (clk_en) begin
      if (pcf_wr) pcf_wp <= pcf_wp + 4'h1;
      if (pcf_rd) begin
        pcf_rp <= pcf_rp + 4'h1;
        rx_valid <= 1'b1;
        rx_word <= pcf_mem[pcf_rp[2:0]];
      end else if (user_ready) begin
        rx_valid <= 1'b0;
      end
    end
  end

  // registers and status
  always_ff @(posedge clock) begin
    if (srst) begin
      lanes_aligned <= 1'b0;
      serial_lpbk <= 1'b0;
    end else if (clk_en) begin
      lanes_aligned <= mode == rpb_pkg::mode_xaui && al_state == rpb_pkg::al_locked; // see [R2]
      serial_lpbk <= ctrl[`RPB_CTRL_LPBK_BIT] &&
                     (mode == rpb_pkg::mode_gige || mode == rpb_pkg::mode_srio); // see [R22]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl <= `RPB_CTRL_RESET;
      skip_pat <= `RPB_SKIP_RESET;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `RPB_ADDR_CTRL) ctrl <= {27'h0, reg_wdata[4:0]};
      if (reg_addr == `RPB_ADDR_SKIP) skip_pat <= reg_wdata[9:0];
    end
  end

  // sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (srst) begin
      pcf_ovf_st <= 1'b0;
      rm_ovf_st <= 1'b0;
      rm_udf_st <= 1'b0;
    end else if (clk_en) begin
      pcf_ovf_st <= pcf_ovf_ev | (pcf_ovf_st & ~(stat_w1c & reg_wdata[4]));
      rm_ovf_st <= rm_ovf_ev | (rm_ovf_st & ~(stat_w1c & reg_wdata[5]));
      rm_udf_st <= rm_udf_ev | (rm_udf_st & ~(stat_w1c & reg_wdata[6]));
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `RPB_ADDR_CTRL: reg_rdata <= ctrl;
          `RPB_ADDR_SKIP: reg_rdata <= {22'h0, skip_pat};
          `RPB_ADDR_STAT: reg_rdata <= {25'h0, rm_udf_st, rm_ovf_st, pcf_ovf_st, pipe_status,
                                        lanes_aligned};
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule : rpb_receiver_backend

// [pkg/rpb_regs.svh]
`ifndef RPB_REGS_SVH
`define RPB_REGS_SVH
`define RPB_ADDR_CTRL 8'h00
`define RPB_ADDR_SKIP 8'h04
`define RPB_ADDR_STAT 8'h08
`define RPB_CTRL_MODE_MSB 2
`define RPB_CTRL_ENH_BIT 3
`define RPB_CTRL_LPBK_BIT 4
`define RPB_CTRL_RESET 32'h00000004
`define RPB_SKIP_RESET 10'h0f4
`define RPB_AL_COLS 3'h4
`define RPB_AL_MISS 3'h4
`define RPB_RM_DEPTH 5'h10
`define RPB_RM_LO 5'h04
`define RPB_RM_MID 5'h08
`define RPB_RM_HI 5'h0c
`define RPB_BASIC_MAX_SKIP 3'h5
`define RPB_PCF_DEPTH_PIPE 4'h8
`define RPB_PCF_DEPTH 4'h4
`define RPB_K28_0 9'h11c
`define RPB_K28_3 9'h17c
`define RPB_K28_5 9'h1bc
`define RPB_K30_7 9'h1fe
`define RPB_D16_2 9'h050
`define RPB_D21_5 9'h0b5
`define RPB_D2_2 9'h042
`define RPB_XGMII_IDLE 8'h07
`define RPB_PST_OK 3'h0
`define RPB_PST_OVF 3'h5
`define RPB_PST_UDF 3'h6
`endif

// [pkg/rpb_pkg.sv]
package rpb_pkg;
  typedef enum logic [2:0] {mode_xaui, mode_pipe, mode_gige, mode_srio, mode_basic} rpb_mode_t;
  typedef enum logic [1:0] {al_hunt, al_acq, al_locked} rpb_al_state_t;
  typedef logic [3:0][9:0] rpb_col_t;
  typedef struct packed {
    logic err;
    logic derr;
    logic k;
    logic [7:0] data;
  } rpb_sym_t;
  typedef rpb_sym_t [7:0] rpb_word_t;
endpackage : rpb_pkg

// [bench/rpb_receiver_backend_props.sv]
`timescale 1ns/1ps
module rpb_receiver_backend_props (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire rpb_pkg::rpb_col_t in_col,
  input wire logic user_ready,
  input wire logic lanes_aligned,
  input wire logic [2:0] pipe_status,
  input wire logic rx_valid,
  input wire rpb_pkg::rpb_word_t rx_word,
  input wire logic serial_lpbk
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic [4:0] ctl;
  logic [2:0] acnt;
  wire logic lane0_a = in_col[0] == 10'h0f3 || in_col[0] == 10'h30c;
  // shadow of mode and loopback bits
  always_ff @(posedge clock) begin
    if (srst) ctl <= 5'h04;
    else if (clk_en && reg_wr && reg_addr == 8'h00) ctl <= reg_wdata[4:0];
  end
  // lane 0 must see /A/ in every aligned column, so it bounds the count
  always_ff @(posedge clock) begin
    if (srst) acnt <= 3'h0;
    else if (clk_en && in_valid && lane0_a && acnt != 3'h4) acnt <= acnt + 3'h1;
  end
  sequence s_held;
    rx_valid && !user_ready;
  endsequence
  property p_hold;
    s_held |=> rx_valid && $stable(rx_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved while held");
  property p_codes;
    pipe_status inside {3'h0, 3'h5, 3'h6};
  endproperty
  a_codes: assert property (p_codes) else $error("bad status code");
  property p_pipe;
    (ctl[2:0] != 3'h1) [*3] |-> pipe_status == 3'h0;
  endproperty
  a_pipe: assert property (p_pipe) else $error("status outside pipe");
  property p_xaui;
    (ctl[2:0] != 3'h0) [*3] |-> !lanes_aligned;
  endproperty
  a_xaui: assert property (p_xaui) else $error("aligned outside xaui");
  property p_rise;
    $rose(lanes_aligned) |-> acnt == 3'h4;
  endproperty
  a_rise: assert property (p_rise) else $error("aligned too early");
  property p_derr;
    rx_valid && rx_word[0].derr |-> rx_word[0].err;
  endproperty
  a_derr: assert property (p_derr) else $error("disparity without code error");
  property p_gige;
    (ctl[2:0] == 3'h2) [*8] ##0 rx_valid |-> rx_word[1] == '0;
  endproperty
  a_gige: assert property (p_gige) else $error("second byte in gige");
  property p_lpbk;
    $stable(ctl) [*2] |-> serial_lpbk == (ctl[4] && ctl[2:0] inside {3'h2, 3'h3});
  endproperty
  a_lpbk: assert property (p_lpbk) else $error("loopback select wrong");
endmodule : rpb_receiver_backend_props
bind rpb_receiver_backend rpb_receiver_backend_props i_rpb_receiver_backend_props (
  .clock(clock), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
  .in_col(in_col), .user_ready(user_ready), .lanes_aligned(lanes_aligned),
  .pipe_status(pipe_status), .rx_valid(rx_valid), .rx_word(rx_word), .serial_lpbk(serial_lpbk));

// [bench/rpb_user_sink.sv]
`timescale 1ns/1ps
module rpb_user_sink (
  input wire logic clock,
  input wire logic srst,
  input wire logic stall,
  input wire logic one_byte,
  input wire logic rx_valid,
  input wire rpb_pkg::rpb_word_t rx_word,
  output logic user_ready
);
  rpb_pkg::rpb_sym_t q[$];
  assign user_ready = !srst && !stall;
  always @(posedge clock) begin
    if (rx_valid && user_ready) begin
      q.push_back(rx_word[0]);
      // both bytes kept to find pairing phase
      if (!one_byte) q.push_back(rx_word[1]);
    end
  end
endmodule : rpb_user_sink

// [bench/tb_rpb_receiver_backend.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module tb_rpb_receiver_backend;
  logic clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0;
  logic stall = 1'b0, one_byte = 1'b0, saw_udf = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
  rpb_pkg::rpb_col_t in_col = '0;
  rpb_pkg::rpb_word_t rx_word;
  logic user_ready, lanes_aligned, rx_valid, serial_lpbk;
  logic [2:0] pipe_status;
  int bad_count = 0, num_checks = 0, off;
  rpb_receiver_backend i_rpb_receiver_backend (.clock(clock), .srst(srst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_col(in_col), .user_ready(user_ready),
    .lanes_aligned(lanes_aligned), .pipe_status(pipe_status), .rx_valid(rx_valid),
    .rx_word(rx_word), .serial_lpbk(serial_lpbk));
  rpb_user_sink i_rpb_user_sink (.clock(clock), .srst(srst), .stall(stall),
    .one_byte(one_byte), .rx_valid(rx_valid), .rx_word(rx_word), .user_ready(user_ready));
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (pipe_status === 3'h6) saw_udf <= 1'b1;
  end
  task automatic rst();
    @(posedge clock);
    srst <= 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    i_rpb_user_sink.q.delete();
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd
  // columns alternate a/b so running disparity stays legal per lane
  task automatic feed(input logic [9:0] a0, b0, ax, bx, input int n);
    repeat (2 * n) begin
      @(posedge clock);
      in_valid <= 1'b1;
      in_col <= {ax, ax, ax, a0};
      {a0, b0, ax, bx} = {b0, a0, bx, ax};
    end
    @(posedge clock);
    in_valid <= 1'b0;
  endtask : feed
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : pause
  function automatic logic has(input logic [10:0] m, input logic [10:0] v);
    has = 1'b0;
    foreach (i_rpb_user_sink.q[i]) if ((i_rpb_user_sink.q[i] & m) === v) has = 1'b1;
  endfunction : has
  task automatic finish_test();
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial begin
    rst();
    rd(8'h00);
    `CHK(rdv, 32'h4)
    rd(8'h04);
    `CHK(rdv, 32'hf4)
    rd(8'h0c);
    `CHK(rdv, 32'h0)
    $display("registers done");
    wr(8'h00, 32'h13);
    feed(10'h2aa, 10'h155, 10'h2aa, 10'h155, 6);
    pause(20);
    `CHK(serial_lpbk, 1'b1)
    off = (i_rpb_user_sink.q[0][7:0] === 8'hb5) ? 0 : 1;
    for (int i = 0; i < 8; i++) `CHK(i_rpb_user_sink.q[i + off][8:0], i % 2 ? 9'h04a : 9'h0b5)
    feed(10'h0fa, 10'h0fa, 10'h0fa, 10'h0fa, 1);
    feed(10'h000, 10'h2aa, 10'h000, 10'h2aa, 2);
    pause(20);
    `CHK(has(11'h1ff, 11'h1bc), 1'b1)
    `CHK(has(11'h600, 11'h600), 1'b1)
    `CHK(has(11'h600, 11'h400), 1'b1)
    @(posedge clock);
    stall <= 1'b1;
    feed(10'h2aa, 10'h155, 10'h2aa, 10'h155, 8);
    pause(10);
    rd(8'h08);
    `CHK(rdv, 32'h10)
    wr(8'h08, 32'h10);
    stall <= 1'b0;
    rd(8'h08);
    `CHK(rdv, 32'h0)
    $display("serial rapidio done");
    rst();
    wr(8'h00, 32'h2);
    one_byte <= 1'b1;
    feed(10'h0fa, 10'h245, 10'h0fa, 10'h245, 10);
    feed(10'h000, 10'h000, 10'h000, 10'h000, 1);
    feed(10'h0fa, 10'h245, 10'h0fa, 10'h245, 10);
    pause(30);
    `CHK(has(11'h1ff, 11'h1fe), 1'b1)
    $display("gige done");
    rst();
    one_byte <= 1'b0;
    wr(8'h00, 32'h1);
    feed(10'h2aa, 10'h2aa, 10'h2aa, 10'h2aa, 6);
    pause(40);
    `CHK(saw_udf, 1'b1)
    rd(8'h08);
    `CHK(rdv[6], 1'b1)
    `CHK(has(11'h7ff, 11'h1fe), 1'b1)
    $display("pipe done");
    rst();
    wr(8'h00, 32'h0);
    feed(10'h0f3, 10'h30c, 10'h0f3, 10'h30c, 4);
    pause(20);
    `CHK(lanes_aligned, 1'b1)
    feed(10'h0f3, 10'h30c, 10'h2aa, 10'h2aa, 4);
    pause(20);
    `CHK(lanes_aligned, 1'b0)
    feed(10'h0f3, 10'h30c, 10'h0f3, 10'h30c, 4);
    pause(20);
    `CHK(lanes_aligned, 1'b1)
    $display("xaui done");
    finish_test();
  end
endmodule : tb_rpb_receiver_backend
